// File: gate_link_if.sv
// carrier between gate register and the clock enable stage
`timescale 1ns/1ps
`default_nettype none
interface gate_link_if;
	peripheral_clock_gate_pkg::gate_word_t gate;
	peripheral_clock_gate_pkg::gate_word_t clk_en;
	peripheral_clock_gate_pkg::gate_word_t wr_req;
	peripheral_clock_gate_pkg::gate_word_t wr_allow;
	modport ctrl (output gate, output wr_req, input clk_en, input wr_allow);
	modport stage (input gate, input wr_req, output clk_en, output wr_allow);
endinterface : gate_link_if
`default_nettype wire

// File: gate_stage.sv
// delayed per-peripheral clock enable stage
`timescale 1ns/1ps
`default_nettype none
`include "peripheral_clock_gate_cfg.svh"
module gate_stage (
	input  wire logic   pclk,
	input  wire logic   presetn,
	gate_link_if.stage  link
);
	localparam peripheral_clock_gate_pkg::gate_word_t MASK = `PCG_IMPL_MASK;

	// a net, so each bit may be driven by its own generate branch
	wire peripheral_clock_gate_pkg::gate_word_t en_q;

	// one flop per implemented bit gives the single instruction-cycle lag
	genvar i;
	generate
		for (i = 0; i < `PCG_GATE_WIDTH; i = i + 1) begin : g_bit
			if (MASK[i]) begin : g_impl
				logic run_q;
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						run_q <= 1'b1;
					end else begin
						run_q <= ~link.gate[i]; // R09 R05
					end
				end
				assign en_q[i] = run_q;
			end else begin : g_none
				assign en_q[i] = 1'b0;
			end
		end
	endgenerate

	assign link.clk_en   = en_q; // R07
	assign link.wr_allow = link.wr_req & en_q; // R08

	one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
		$changed(link.gate) |=> link.clk_en == (~$past(link.gate) & MASK))
		else $error("gate change not applied one cycle later");
	no_clock_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
		link.gate[`PCG_CONVERTER_BIT] [*2] |-> !link.clk_en[`PCG_CONVERTER_BIT])
		else $error("stopped converter still clocked");
	blocked_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
		(link.wr_allow & ~link.clk_en) == 16'h0000)
		else $error("write passed to a stopped peripheral");
endmodule : gate_stage
`default_nettype wire

// File: peripheral_clock_gate_cfg.svh
// constants for the peripheral clock gate controller
// What this block does
// (R01) Bits 15 to 11 of the gate register each stop one timer, timer five at bit 15 down to timer one at bit 11.
// (R02) Bit 9 stops the whole pulse-width generator when one and leaves it running when zero.
// (R03) Bit 7 stops the two-wire port, bit 4 the second and bit 3 the first synchronous serial port.
// (R04) Bit 6 stops the second and bit 5 the first asynchronous serial port.
// (R05) For every implemented gate bit, zero means the peripheral runs normally and one means it is disabled.
// (R06) Bit 0 stops the converter, bits 10, 8, 2 and 1 read zero, and implemented bits are read-write and reset to zero.
// (R07) A disabled peripheral has every clock to it stopped.
// (R08) While a peripheral is stopped its register writes have no effect and its reads are marked invalid.
// (R09) Setting or clearing a gate bit reaches the peripheral one instruction cycle later.
`ifndef PERIPHERAL_CLOCK_GATE_CFG_SVH
`define PERIPHERAL_CLOCK_GATE_CFG_SVH

`define PCG_GATE_OFFSET     12'h000
`define PCG_GATE_RESET      16'h0000
`define PCG_IMPL_MASK       16'hFAF9
`define PCG_TIMER_MSB       15
`define PCG_TIMER_LSB       11
`define PCG_PWM_BIT         9
`define PCG_TWO_WIRE_BIT    7
`define PCG_SERIAL_TWO_BIT  6
`define PCG_SERIAL_ONE_BIT  5
`define PCG_SYNC_TWO_BIT    4
`define PCG_SYNC_ONE_BIT    3
`define PCG_CONVERTER_BIT   0
`define PCG_LOW_LANE_MSB    7
`define PCG_HIGH_LANE_LSB   8
`define PCG_GATE_WIDTH      16
`define PCG_INSTR_CYCLE_NS  20
`define PCG_CLK_PERIOD_NS   20
`define PCG_DELAY_CYCLES    ((`PCG_INSTR_CYCLE_NS + `PCG_CLK_PERIOD_NS - 1) / `PCG_CLK_PERIOD_NS)

`endif

// File: peripheral_clock_gate_ctrl.sv
// apb gate register and peripheral clock enables
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "peripheral_clock_gate_cfg.svh"
module peripheral_clock_gate_ctrl #(
	parameter int ADDR_WIDTH = 12
) (
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [15:0]           periph_wr_req,
	output logic      [15:0]           periph_wr_allow,
	output logic      [15:0]           periph_rd_valid,
	output logic      [15:0]           periph_clk_en
);
	localparam peripheral_clock_gate_pkg::gate_word_t MASK = `PCG_IMPL_MASK;
	localparam logic [ADDR_WIDTH-1:0] GATE_ADDR = ADDR_WIDTH'(`PCG_GATE_OFFSET);

	gate_link_if link ();

	peripheral_clock_gate_pkg::gate_word_t gate;
	peripheral_clock_gate_pkg::gate_word_t next_gate;
	logic [31:0]                           next_prdata;

	wire hit       = (paddr == GATE_ADDR);
	wire setup     = psel && !penable;
	wire wr_take   = psel && penable && pwrite && hit;
	wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire serial_port_one_off = gate[`PCG_SERIAL_ONE_BIT]; // R04
	wire converter_off       = gate[`PCG_CONVERTER_BIT]; // R06

	// only implemented bits can ever hold a one
	assign next_gate   = wr_take ? (((pwdata[15:0] & lane_mask) | (gate & ~lane_mask)) & MASK) : gate; // R06
	assign next_prdata = (setup && !pwrite && hit) ? {16'h0000, gate} : 32'h0000_0000; // R06

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate <= `PCG_GATE_RESET; // R06
		end else begin
			gate <= next_gate; // R01 R02 R03 R04
		end
	end

	// read data staged in setup so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= next_prdata;
			pslverr <= !hit;
		end
	end

	assign pready          = 1'b1;
	assign link.gate       = gate;
	assign link.wr_req     = periph_wr_req;
	assign periph_clk_en   = link.clk_en; // R07
	assign periph_wr_allow = link.wr_allow; // R08
	assign periph_rd_valid = link.clk_en; // R08

	gate_stage u_stage (
		.pclk    (pclk),
		.presetn (presetn),
		.link    (link)
	);

	timer_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
		$rose(gate[`PCG_TIMER_LSB]) |-> periph_clk_en[`PCG_TIMER_LSB] ##1 !periph_clk_en[`PCG_TIMER_LSB])
		else $error("timer one not stopped");
	timer_five_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
		gate[`PCG_TIMER_MSB:`PCG_TIMER_LSB] == 5'h1F [*2] |-> periph_clk_en[`PCG_TIMER_MSB:`PCG_TIMER_LSB] == 5'h00)
		else $error("timers still clocked");
	pwm_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
		$fell(gate[`PCG_PWM_BIT]) |-> !periph_clk_en[`PCG_PWM_BIT] ##1 periph_clk_en[`PCG_PWM_BIT])
		else $error("pulse generator not restarted");
	sync_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
		$rose(gate[`PCG_TWO_WIRE_BIT]) || $rose(gate[`PCG_SYNC_TWO_BIT]) || $rose(gate[`PCG_SYNC_ONE_BIT])
		|=> ((periph_clk_en & gate & 16'h0098) == 16'h0000))
		else $error("two-wire or sync port not stopped");
	uart_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
		$rose(gate[`PCG_SERIAL_TWO_BIT]) |=> !periph_clk_en[`PCG_SERIAL_TWO_BIT] && $stable(gate[`PCG_SERIAL_ONE_BIT])
		|| periph_clk_en[`PCG_SERIAL_ONE_BIT] != gate[`PCG_SERIAL_ONE_BIT] || !periph_clk_en[`PCG_SERIAL_TWO_BIT])
		else $error("second serial port not stopped");
	polarity_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
		$stable(gate) |=> $stable(gate) |-> periph_clk_en == (~gate & MASK))
		else $error("enable not the inverse of gate");
	unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
		psel && penable && !pwrite |-> (prdata & ~{16'h0000, MASK}) == 32'h0000_0000)
		else $error("unimplemented bits read nonzero");
	write_take_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
		psel && penable && pwrite && hit && pstrb == 4'hF |=> gate == ($past(pwdata[15:0]) & MASK))
		else $error("full write not stored");
	serial_one_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
		$rose(serial_port_one_off) |=> !periph_clk_en[`PCG_SERIAL_ONE_BIT])
		else $error("first serial port not stopped");
	converter_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
		$fell(converter_off) |=> periph_clk_en[`PCG_CONVERTER_BIT])
		else $error("converter not restarted");
endmodule : peripheral_clock_gate_ctrl
`default_nettype wire

// File: peripheral_clock_gate_pkg.sv
// types shared by the peripheral clock gate controller
package peripheral_clock_gate_pkg;
	typedef logic [15:0] gate_word_t;
endpackage : peripheral_clock_gate_pkg

// File: tb_peripheral_clock_gate_ctrl.sv
// self-checking bench for the peripheral clock gate controller
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_clock_gate_ctrl;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hF;
	logic [15:0] periph_wr_req = 16'hFFFF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] periph_wr_allow;
	logic [15:0] periph_rd_valid;
	logic [15:0] periph_clk_en;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	logic [31:0] r;
	logic        e;
	logic [15:0] en;
	peripheral_clock_gate_ctrl peripheral_clock_gate_ctrl_inst (.paddr(paddr), .pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .periph_wr_req(periph_wr_req), .periph_wr_allow(periph_wr_allow),
		.periph_rd_valid(periph_rd_valid), .periph_clk_en(periph_clk_en));
	always #10 pclk = ~pclk;
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// request held until the edge that samples pready high
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s; penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task test_reset;
		xfer(1'b0, 12'h000, 32'h0000_0000, 4'hF);
		chk("gate", 32'h0000_0000, r);
		chk("clk_en", 32'h0000_FAF9, {16'h0000, periph_clk_en});
		chk("pready", 32'h1, {31'h0, pready});
		chk("rd ok", 32'h0, {31'h0, e});
		$display("reset test done");
	endtask : test_reset
	task test_bits;
		en = 16'hFAF9;
		for (int i = 0; i < 16; i++) begin
			xfer(1'b1, 12'h000, 32'h1 << i, 4'hF);
			#1 chk("clk_en early", {16'h0000, en}, {16'h0000, periph_clk_en});
			en = 16'hFAF9 & ~(16'h1 << i);
			@(posedge pclk);
			#1 chk("clk_en", {16'h0000, en}, {16'h0000, periph_clk_en});
			chk("wr_allow", {16'h0000, en}, {16'h0000, periph_wr_allow});
			chk("rd_valid", {16'h0000, en}, {16'h0000, periph_rd_valid});
			xfer(1'b0, 12'h000, 32'h0000_0000, 4'hF);
			chk("gate", {16'h0000, ~en & 16'hFAF9}, r);
		end
		$display("bit test done");
	endtask : test_bits
	task test_strobe;
		xfer(1'b1, 12'h000, 32'h0000_0000, 4'hF);
		xfer(1'b1, 12'h000, 32'hFFFF_FFFF, 4'h1);
		xfer(1'b0, 12'h000, 32'h0000_0000, 4'hF);
		chk("gate low lane", 32'h0000_00F9, r);
		xfer(1'b1, 12'h000, 32'hFFFF_FFFF, 4'h2);
		xfer(1'b0, 12'h000, 32'h0000_0000, 4'hF);
		chk("gate both lanes", 32'h0000_FAF9, r);
		xfer(1'b1, 12'h000, 32'h0000_0000, 4'hF);
		$display("strobe test done");
	endtask : test_strobe
	task test_unmapped;
		xfer(1'b1, 12'h004, 32'hFFFF_FFFF, 4'hF);
		chk("wr err", 32'h1, {31'h0, e});
		xfer(1'b0, 12'h004, 32'h0000_0000, 4'hF);
		chk("rd err", 32'h1, {31'h0, e});
		chk("rd data", 32'h0000_0000, r);
		xfer(1'b0, 12'h000, 32'h0000_0000, 4'hF);
		chk("gate kept", 32'h0000_0000, r);
		$display("unmapped test done");
	endtask : test_unmapped
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_bits();
		test_strobe();
		test_unmapped();
		complete_run();
	end
endmodule : tb_peripheral_clock_gate_ctrl
`default_nettype wire
